// File: common/irq_wake_pkg.sv
// Constants for the interrupt option and wake control block.
// Assumes an APB slave with 32-bit data and one word per register.
package irq_wake_pkg;
  localparam logic [11:0] OPTION_ADDR = 12'h0C8;
  localparam logic [11:0] MASK_ADDR = 12'h0D0;
  localparam logic [11:0] STATUS_ADDR = 12'h0D4;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam int LEVEL_BIT = 6;
  localparam int POLARITY_BIT = 5;
  localparam int GLOBAL_BIT = 4;
  // Mask register layout.
  localparam int TIMER_MASK_BIT = 0;
  localparam int CONV_MASK_BIT = 1;
  localparam int RL_OVF_MASK_BIT = 2;
  localparam int RL_CMP_MASK_BIT = 3;
  localparam int RL_EDGE_MASK_BIT = 4;
  localparam int SERIAL_MASK_BIT = 5;
  localparam int NUM_VECTORS = 4;
  localparam int STAB_TIME_US = 8;
  localparam int CLK_MHZ = 40;
  localparam int STAB_CYCLES = STAB_TIME_US * CLK_MHZ;
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_WAIT = 4'b0010,
    ST_STOP = 4'b0100,
    ST_STAB = 4'b1000
  } power_state_t;
  typedef enum logic [1:0] {
    CTX_MAIN = 2'h0,
    CTX_MASKABLE = 2'h1,
    CTX_NMI = 2'h2
  } core_ctx_t;
endpackage : irq_wake_pkg

// File: src/edge_sync.sv
// Three-stage synchroniser with agreement check and edge outputs.
// Assumes an asynchronous input pin.
`timescale 1ns/100ps
`default_nettype none
module edge_sync (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } sync_state_t;
  sync_state_t st_q, st_d;
  always_comb begin
    st_d = st_q;
    st_d.s1 = pin;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // A change counts only once the later two stages agree.
    if (st_q.s2 == st_q.s3) begin
      st_d.lvl = st_q.s3;
    end
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, lvl: 1'b1};
    end else begin
      st_q <= st_d;
    end
  end
  assign level = st_q.lvl;
  assign rise = st_d.lvl & ~st_q.lvl;
  assign fall = ~st_d.lvl & st_q.lvl;
endmodule : edge_sync
`default_nettype wire

// File: src/irq_wake_ctrl.sv
// Interrupt option register, vector routing and low-power wake control.
// Assumes an APB master, a core that pulses its instruction-boundary and
// vector-acknowledge strobes, and peripherals that present event levels.
// Operation
// [RULE1] Option register is write-only at 0C8h; whole-byte writes only.
// [RULE2] Reset clears the option register to zero.
// [RULE3] Bit 6 set makes source one level sensitive, clear edge sensitive.
// [RULE4] Bit 5 selects the edge polarity of source two.
// [RULE5] Bit 5 one means rising edge, zero means falling edge.
// [RULE6] Bit 4 is global enable; clear blocks all but non-maskable.
// [RULE7] With global enable clear, non-maskable is serviced but cannot wake.
// [RULE8] With global enable clear, only reset leaves wait or stop.
// [RULE9] Timer overflow and converter end, each masked, request vector four.
// [RULE10] Reload timer overflow, compare, input edge, each masked, request vector three.
// [RULE11] Serial end of transmission, masked, requests vector two.
// [RULE12] Ports A and B request vector one, port C vector two.
// [RULE13] A level request is not stored; source holds it until sampled.
// [RULE14] Wait halts the core while clock and peripherals keep running.
// [RULE15] Wake from wait resumes with no stabilisation delay.
// [RULE16] Stop only with watchdog off; oscillator halts until interrupt or reset.
// [RULE17] Wake from stop inserts an oscillator stabilisation delay.
// [RULE18] Reset during wait or stop runs the ordinary reset procedure.
// [RULE19] From main, the waking interrupt is serviced, then next instruction.
// [RULE20] From non-maskable routine, any interrupt wakes; resume, no service.
// [RULE21] From maskable routine, maskable wake resumes that routine first.
// [RULE22] From maskable routine, non-maskable wake is serviced, then resume.
// [RULE23] With watchdog active, stop executes as wait.
// [RULE24] Wait and stop are refused while an enabled request is pending.
// [RULE25] Interrupt wake leaves the oscillator selection unchanged.
// [RULE26] Wake request is enabled maskable requests or non-maskable, under global enable.
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/100ps
`default_nettype none
module irq_wake_ctrl
  import irq_wake_pkg::*;
#(
  parameter int STAB_COUNT = STAB_CYCLES,
  parameter int PORT_A_W = 4,
  parameter int PORT_B_W = 6,
  parameter int PORT_C_W = 3
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nmi_pin,
  input wire logic ext_src1_pin,
  input wire logic ext_src2_pin,
  input wire logic timer_zero_flag,
  input wire logic converter_done_flag,
  input wire logic reload_overflow_flag,
  input wire logic reload_compare_flag,
  input wire logic reload_input_edge_flag,
  input wire logic serial_running_flag,
  input wire logic [PORT_A_W-1:0] port_a_irq,
  input wire logic [PORT_B_W-1:0] port_b_irq,
  input wire logic [PORT_C_W-1:0] port_c_irq,
  input wire logic watchdog_active,
  input wire logic instr_boundary,
  input wire logic wait_exec,
  input wire logic stop_exec,
  input wire logic vector_ack,
  input wire logic [2:0] ack_vector,
  input wire logic reti,
  input wire logic osc_select_in,
  output logic [2:0] take_vector,
  output logic take_valid,
  output logic core_halt,
  output logic osc_run,
  output logic osc_select,
  output logic [1:0] core_ctx,
  output logic [1:0] power_state
);
  //////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [7:0] option;
    logic [7:0] mask;
    logic nmi_latch;
    logic src1_latch;
    logic src2_latch;
    power_state_t pstate;
    core_ctx_t ctx;
    core_ctx_t saved_ctx;
    logic from_stop;
    logic [15:0] stab_cnt;
    logic [31:0] rdata;
    logic osc_sel;
  } ctrl_state_t;
  ctrl_state_t st_q, st_d;
  logic nmi_fall;
  logic s1_lvl, s1_fall;
  logic s2_rise, s2_fall;
  logic src1_level_select, src2_edge_polarity, global_irq_enable;
  logic [NUM_VECTORS:1] vec_req;
  logic maskable_any, wake_req, nmi_pend;
  logic apb_write, apb_read;
  logic [2:0] best_vec;

  edge_sync u_nmi_sync (
    .clk(clk), .nrst(nrst), .pin(nmi_pin),
    .level(), .rise(), .fall(nmi_fall)
  );
  edge_sync u_src1_sync (
    .clk(clk), .nrst(nrst), .pin(ext_src1_pin),
    .level(s1_lvl), .rise(), .fall(s1_fall)
  );
  edge_sync u_src2_sync (
    .clk(clk), .nrst(nrst), .pin(ext_src2_pin),
    .level(), .rise(s2_rise), .fall(s2_fall)
  );
  // The NMI and source one never trigger on a rising edge, so their
  // rising-edge outputs are left open.

  // Lowest-numbered pending vector wins; source one has the top priority.
  function automatic logic [2:0] pick_vector(input logic [NUM_VECTORS:1] req);
    pick_vector = 3'h0;
    for (int i = NUM_VECTORS; i >= 1; i--) begin
      if (req[i]) begin
        pick_vector = 3'(i);
      end
    end
  endfunction : pick_vector

  //////////////////////////////////////////////////////////////////////////
  assign src1_level_select = st_q.option[LEVEL_BIT]; // see [RULE3]
  assign src2_edge_polarity = st_q.option[POLARITY_BIT]; // see [RULE4]
  assign global_irq_enable = st_q.option[GLOBAL_BIT]; // see [RULE6]

  always_comb begin
    // Source one: a live low level is used unlatched in level mode.
    vec_req[1] = (src1_level_select ? ~s1_lvl : st_q.src1_latch) // see [RULE13]
               | (|port_a_irq) | (|port_b_irq); // see [RULE12]
    vec_req[2] = st_q.src2_latch | (|port_c_irq) // see [RULE12]
               | (serial_running_flag & st_q.mask[SERIAL_MASK_BIT]); // see [RULE11]
    vec_req[3] = (reload_overflow_flag & st_q.mask[RL_OVF_MASK_BIT]) // see [RULE10]
               | (reload_compare_flag & st_q.mask[RL_CMP_MASK_BIT])
               | (reload_input_edge_flag & st_q.mask[RL_EDGE_MASK_BIT]);
    vec_req[4] = (timer_zero_flag & st_q.mask[TIMER_MASK_BIT]) // see [RULE9]
               | (converter_done_flag & st_q.mask[CONV_MASK_BIT]);
  end

  assign maskable_any = global_irq_enable & (|vec_req); // see [RULE6]
  assign nmi_pend = st_q.nmi_latch;
  assign wake_req = global_irq_enable & ((|vec_req) | nmi_pend); // see [RULE26] [RULE7]
  assign best_vec = pick_vector(vec_req);

  //////////////////////////////////////////////////////////////////////////
  assign apb_write = psel & penable & pwrite;
  assign apb_read = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    st_d = st_q;
    // Edge latches: the set wins over the acknowledge in the same cycle.
    if (vector_ack && ack_vector == 3'h0) begin
      st_d.nmi_latch = 1'b0;
    end
    if (nmi_fall) begin
      st_d.nmi_latch = 1'b1;
    end
    if (vector_ack && ack_vector == 3'h1) begin
      st_d.src1_latch = 1'b0;
    end
    if (s1_fall && !src1_level_select) begin
      st_d.src1_latch = 1'b1;
    end
    if (vector_ack && ack_vector == 3'h2) begin
      st_d.src2_latch = 1'b0;
    end
    if (src2_edge_polarity ? s2_rise : s2_fall) begin // see [RULE5]
      st_d.src2_latch = 1'b1;
    end
    // Whole-byte write only; reads return zero for the option register.
    if (apb_write && paddr == OPTION_ADDR) begin
      st_d.option = pwdata[7:0]; // see [RULE1]
    end
    if (apb_write && paddr == MASK_ADDR) begin
      st_d.mask = pwdata[7:0];
    end
    if (apb_read) begin
      unique case (paddr)
        MASK_ADDR: st_d.rdata = {24'h000000, st_q.mask};
        STATUS_ADDR: st_d.rdata = {21'h000000, st_q.osc_sel, st_q.from_stop,
                                   st_q.ctx, st_q.pstate, st_q.nmi_latch,
                                   st_q.src2_latch, st_q.src1_latch};
        default: st_d.rdata = 32'h00000000;
      endcase
    end
    // Context tracking follows vector acknowledges and returns.
    if (vector_ack && st_q.pstate == ST_RUN) begin
      if (ack_vector == 3'h0) begin
        st_d.saved_ctx = st_q.ctx;
        st_d.ctx = CTX_NMI;
      end else begin
        st_d.ctx = CTX_MASKABLE;
      end
    end else if (reti) begin
      st_d.ctx = (st_q.ctx == CTX_NMI) ? st_q.saved_ctx : CTX_MAIN;
    end
    unique case (st_q.pstate)
      ST_RUN: begin
        st_d.stab_cnt = 16'h0000;
        // Refuse to sleep with an enabled request already pending.
        if ((wait_exec || stop_exec) && !(maskable_any || nmi_pend)) begin // see [RULE24]
          if (stop_exec && !watchdog_active) begin // see [RULE23] [RULE16]
            st_d.pstate = ST_STOP;
            st_d.from_stop = 1'b1;
          end else begin
            st_d.pstate = ST_WAIT; // see [RULE14]
            st_d.from_stop = 1'b0;
          end
        end
      end
      ST_WAIT: begin
        if (wake_req) begin
          st_d.pstate = ST_RUN; // see [RULE15] [RULE8]
        end
      end
      ST_STOP: begin
        if (wake_req) begin
          st_d.pstate = ST_STAB; // see [RULE17] [RULE8]
        end
      end
      ST_STAB: begin
        st_d.stab_cnt = st_q.stab_cnt + 16'h0001;
        if (st_q.stab_cnt == 16'(STAB_COUNT - 1)) begin
          st_d.pstate = ST_RUN;
        end
      end
      default: st_d.pstate = ST_RUN;
    endcase
    // The clock source choice is only changed by its own input while running.
    if (st_q.pstate == ST_RUN) begin
      st_d.osc_sel = osc_select_in; // see [RULE25]
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      // Any reset lands in the ordinary run state, never a resume.
      st_q <= '{option: OPTION_RESET, mask: MASK_RESET, nmi_latch: 1'b0, // see [RULE2] [RULE18]
                src1_latch: 1'b0, src2_latch: 1'b0, pstate: ST_RUN,
                ctx: CTX_MAIN, saved_ctx: CTX_MAIN, from_stop: 1'b0,
                stab_cnt: 16'h0000, rdata: 32'h00000000, osc_sel: 1'b0};
    end else begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Vector decision at each instruction boundary while running.
  always_comb begin
    take_valid = 1'b0;
    take_vector = 3'h0;
    if (instr_boundary && st_q.pstate == ST_RUN) begin
      if (nmi_pend && st_q.ctx != CTX_NMI) begin
        take_valid = 1'b1; // see [RULE22] [RULE7]
        take_vector = 3'h0;
      end else if (maskable_any && st_q.ctx == CTX_MAIN) begin
        take_valid = 1'b1; // see [RULE19] [RULE21] [RULE20]
        take_vector = best_vec;
      end
    end
  end

  assign prdata = st_q.rdata;
  assign core_halt = (st_q.pstate != ST_RUN);
  assign osc_run = (st_q.pstate != ST_STOP);
  assign osc_select = st_q.osc_sel;
  assign core_ctx = st_q.ctx;
  assign power_state = {st_q.pstate[3] | st_q.pstate[2], st_q.pstate[3] | st_q.pstate[1]};

  //////////////////////////////////////////////////////////////////////////
  option_reset_a: assert property (@(posedge clk) $rose(nrst) |-> st_q.option == 8'h00) // see [RULE2]
    else $error("option register not clear after reset");
  option_write_a: assert property (@(posedge clk) disable iff (!nrst) // see [RULE1]
    apb_write && paddr == OPTION_ADDR |=> st_q.option == $past(pwdata[7:0]))
    else $error("option write lost");
  option_read_a: assert property (@(posedge clk) disable iff (!nrst) // see [RULE1]
    apb_read && paddr == OPTION_ADDR |=> prdata == 32'h00000000)
    else $error("option register readable");
  sleep_block_a: assert property (@(posedge clk) disable iff (!nrst) // see [RULE24]
    st_q.pstate == ST_RUN && (maskable_any || nmi_pend) |=> st_q.pstate == ST_RUN)
    else $error("slept with request pending");
  stop_wd_a: assert property (@(posedge clk) disable iff (!nrst) // see [RULE23]
    st_q.pstate == ST_RUN && stop_exec && watchdog_active && !maskable_any && !nmi_pend
    |=> st_q.pstate == ST_WAIT)
    else $error("stop taken with watchdog active");
  wait_wake_a: assert property (@(posedge clk) disable iff (!nrst) // see [RULE15]
    st_q.pstate == ST_WAIT && wake_req |=> !core_halt)
    else $error("wait wake delayed");
  no_wake_a: assert property (@(posedge clk) disable iff (!nrst) // see [RULE8]
    st_q.pstate == ST_WAIT && !global_irq_enable |=> st_q.pstate == ST_WAIT)
    else $error("woke with global enable clear");
  stop_stab_a: assert property (@(posedge clk) disable iff (!nrst) // see [RULE17]
    st_q.pstate == ST_STOP && wake_req |=> core_halt [*8])
    else $error("stop wake without delay");
  nmi_mode_a: assert property (@(posedge clk) disable iff (!nrst) // see [RULE20]
    st_q.ctx == CTX_NMI |-> !take_valid)
    else $error("service taken in nmi mode");
  mask_gate_a: assert property (@(posedge clk) disable iff (!nrst) // see [RULE6]
    !global_irq_enable |-> !(take_valid && take_vector != 3'h0))
    else $error("maskable taken while disabled");
  cover_wait_c: cover property (@(posedge clk) st_q.pstate == ST_WAIT ##1 st_q.pstate == ST_RUN);
  cover_stop_c: cover property (@(posedge clk) st_q.pstate == ST_STAB ##1 st_q.pstate == ST_RUN);
  cover_nmi_c: cover property (@(posedge clk) take_valid && take_vector == 3'h0);
  cover_vec4_c: cover property (@(posedge clk) take_valid && take_vector == 3'h4);
endmodule : irq_wake_ctrl
`default_nettype wire

// File: tb/core_model.sv
// Behavioural core: instruction boundaries while running, vector acknowledge, return.
// Assumes take_valid and take_vector are judged during instr_boundary.
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic core_halt,
  input wire logic take_valid,
  input wire logic [2:0] take_vector,
  output logic instr_boundary,
  output logic vector_ack,
  output logic [2:0] ack_vector,
  output logic reti,
  output logic [2:0] last_vec,
  output logic [7:0] n_taken
);
  logic [1:0] cnt_q;
  logic [2:0] svc_q;
  // A halted core issues no boundaries, so nothing is taken while asleep.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 2'h0;
      svc_q <= 3'h0;
      instr_boundary <= 1'b0;
      vector_ack <= 1'b0;
      ack_vector <= 3'h0;
      reti <= 1'b0;
      last_vec <= 3'h7;
      n_taken <= 8'h00;
    end else begin
      cnt_q <= core_halt ? cnt_q : cnt_q + 2'h1;
      instr_boundary <= !core_halt && cnt_q == 2'h2;
      vector_ack <= instr_boundary && take_valid;
      ack_vector <= take_vector;
      reti <= svc_q == 3'h1;
      svc_q <= (instr_boundary && take_valid) ? 3'h4 : (svc_q != 3'h0 ? svc_q - 3'h1 : svc_q);
      if (instr_boundary && take_valid) begin
        last_vec <= take_vector;
        n_taken <= n_taken + 8'h01;
      end
    end
  end
endmodule : core_model
`default_nettype wire

// File: tb/testbench.sv
// Self-checking bench for the interrupt option and wake controller.
// Assumes a zero-wait APB slave and the core model on the core side.
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import irq_wake_pkg::*;
  localparam int STAB = 10;
  localparam logic [2:0] VEC [9] = '{3'h4, 3'h4, 3'h3, 3'h3, 3'h3, 3'h2, 3'h1, 3'h1, 3'h2};
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic nmi_pin = 1'b1;
  logic src1 = 1'b1;
  logic src2 = 1'b1;
  logic wd = 1'b0;
  logic wait_exec = 1'b0;
  logic stop_exec = 1'b0;
  logic osc_in = 1'b0;
  logic [8:0] ev = 9'h000;
  logic [31:0] prdata;
  logic pready, pslverr, take_valid, core_halt, osc_run, osc_select;
  logic instr_boundary, vector_ack, reti;
  logic [2:0] take_vector, ack_vector, last_vec;
  logic [1:0] core_ctx, power_state;
  logic [7:0] n_taken, n0;
  int num_errors = 0;
  int total_checks = 0;
  int cycles = 0;
  always #12.5 clk = ~clk;
  irq_wake_ctrl #(.STAB_COUNT(STAB)) dut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .nmi_pin(nmi_pin), .ext_src1_pin(src1),
    .ext_src2_pin(src2), .timer_zero_flag(ev[0]), .converter_done_flag(ev[1]),
    .reload_overflow_flag(ev[2]), .reload_compare_flag(ev[3]),
    .reload_input_edge_flag(ev[4]), .serial_running_flag(ev[5]),
    .port_a_irq({3'h0, ev[6]}), .port_b_irq({5'h00, ev[7]}), .port_c_irq({2'h0, ev[8]}),
    .watchdog_active(wd), .instr_boundary(instr_boundary), .wait_exec(wait_exec),
    .stop_exec(stop_exec), .vector_ack(vector_ack), .ack_vector(ack_vector), .reti(reti),
    .osc_select_in(osc_in), .take_vector(take_vector), .take_valid(take_valid),
    .core_halt(core_halt), .osc_run(osc_run), .osc_select(osc_select),
    .core_ctx(core_ctx), .power_state(power_state));
  core_model model (.clk(clk), .nrst(nrst), .core_halt(core_halt), .take_valid(take_valid),
    .take_vector(take_vector), .instr_boundary(instr_boundary), .vector_ack(vector_ack),
    .ack_vector(ack_vector), .reti(reti), .last_vec(last_vec), .n_taken(n_taken));
  ////////////////////////////////////////////////////////////////////////////////
  task summarize;
    $display("Checks %0d, mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize
  task check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Each transfer starts one edge later so no signal is driven twice in a step.
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Only the bench timeout ends a wait for the slave's answer.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task wait_state(input logic [1:0] exp, input int max);
    int n;
    n = 0;
    while (power_state !== exp && n < max) begin
      @(posedge clk);
      n++;
    end
    check(32'(power_state), 32'(exp));
  endtask : wait_state
  task took(input logic t, input logic [2:0] v);
    cyc(12);
    if (t) check({n_taken != n0, last_vec}, {1'b1, v});
    else check(32'(n_taken), 32'(n0));
    n0 = n_taken;
  endtask : took
  task sleep(input logic stop);
    if (stop) stop_exec <= 1'b1;
    else wait_exec <= 1'b1;
    @(posedge clk);
    stop_exec <= 1'b0;
    wait_exec <= 1'b0;
  endtask : sleep
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    int n;
    cyc(2);
    nrst <= 1'b1;
    apb(1'b0, OPTION_ADDR, 32'h0, q);
    check(q, 32'h0);
    check(32'(pslverr), 32'h0);
    apb(1'b0, 12'h0FC, 32'h0, q);
    check(q, 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0, q);
    check(q, 32'h8);
    apb(1'b1, MASK_ADDR, 32'h3F, q);
    n0 = n_taken;
    ev <= 9'h001;
    took(1'b0, 3'h0);
    apb(1'b1, OPTION_ADDR, 32'h10, q);
    took(1'b1, 3'h4);
    ev <= 9'h000;
    cyc(12);
    $display("Test reset and enable done");
    // Second pass clears every mask; the port lines have no mask here.
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, MASK_ADDR, m == 0 ? 32'h3F : 32'h0, q);
      for (int i = 0; i < 9; i++) begin
        n0 = n_taken;
        ev <= 9'h001 << i;
        took(m == 0 || i > 5, VEC[i]);
        ev <= 9'h000;
        cyc(12);
      end
    end
    apb(1'b1, MASK_ADDR, 32'h3F, q);
    $display("Test routing done");
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, OPTION_ADDR, p == 0 ? 32'h30 : 32'h10, q);
      n0 = n_taken;
      src2 <= 1'b0;
      took(p == 1, 3'h2);
      src2 <= 1'b1;
      took(p == 0, 3'h2);
    end
    src1 <= 1'b0;
    took(1'b1, 3'h1);
    took(1'b0, 3'h0);
    src1 <= 1'b1;
    apb(1'b1, OPTION_ADDR, 32'h50, q);
    n0 = n_taken;
    src1 <= 1'b0;
    took(1'b1, 3'h1);
    src1 <= 1'b1;
    cyc(12);
    n0 = n_taken;
    took(1'b0, 3'h0);
    apb(1'b1, OPTION_ADDR, 32'h00, q);
    n0 = n_taken;
    nmi_pin <= 1'b0;
    took(1'b1, 3'h0);
    nmi_pin <= 1'b1;
    $display("Test external sources done");
    apb(1'b1, OPTION_ADDR, 32'h10, q);
    sleep(1'b0);
    wait_state(2'h1, 4);
    check({core_halt, osc_run}, 2'h3);
    n0 = n_taken;
    ev <= 9'h001;
    wait_state(2'h0, 3);
    took(1'b1, 3'h4);
    sleep(1'b0);
    cyc(2);
    check(32'(power_state), 32'h0);
    ev <= 9'h000;
    cyc(12);
    osc_in <= 1'b1;
    cyc(2);
    sleep(1'b1);
    wait_state(2'h2, 4);
    check(32'(osc_run), 32'h0);
    osc_in <= 1'b0;
    cyc(4);
    check(32'(osc_select), 32'h1);
    n0 = n_taken;
    ev <= 9'h040;
    wait_state(2'h3, 8);
    n = 0;
    while (power_state !== 2'h0 && n < 40) begin
      @(posedge clk);
      n++;
    end
    check(32'(n >= STAB - 1 && n <= STAB + 1), 32'h1);
    took(1'b1, 3'h1);
    ev <= 9'h000;
    wd <= 1'b1;
    cyc(12);
    sleep(1'b1);
    wait_state(2'h1, 4);
    ev <= 9'h001;
    wait_state(2'h0, 3);
    ev <= 9'h000;
    wd <= 1'b0;
    $display("Test power modes done");
    apb(1'b1, OPTION_ADDR, 32'h00, q);
    sleep(1'b0);
    wait_state(2'h1, 4);
    ev <= 9'h001;
    nmi_pin <= 1'b0;
    cyc(12);
    check(32'(power_state), 32'h1);
    nrst <= 1'b0;
    cyc(2);
    nrst <= 1'b1;
    ev <= 9'h000;
    nmi_pin <= 1'b1;
    cyc(1);
    check(32'(power_state), 32'h0);
    check(32'(core_ctx), 32'h0);
    apb(1'b0, STATUS_ADDR, 32'h0, q);
    check(q, 32'h8);
    $display("Test reset from sleep done");
    summarize();
  end
endmodule : testbench
`default_nettype wire
